// ### include/dmsc_defs.svh
// Offsets, field positions, reset values and timing counts of the Modbus serial configuration block
`ifndef DMSC_DEFS_SVH
`define DMSC_DEFS_SVH

// Register indices; byte address is four times the index
`define DMSC_IDX_NODE_ADDR 14'h0425
`define DMSC_IDX_BAUD 14'h0426
`define DMSC_IDX_PARITY 14'h0427
`define DMSC_IDX_STOP_METHOD 14'h0428
`define DMSC_IDX_DETECT_EN 14'h0429
`define DMSC_IDX_DETECT_TIME 14'h0435
`define DMSC_IDX_RELOAD 14'h0B57
`define DMSC_IDX_IRQ_STATUS 14'h0500
`define DMSC_IDX_IRQ_CLEAR 14'h0501
`define DMSC_IDX_IRQ_ENABLE 14'h0502
`define DMSC_IDX_ACTIVE 14'h0503

// Reset values
`define DMSC_RST_NODE_ADDR 8'h1F
`define DMSC_RST_BAUD 4'h3
`define DMSC_RST_PARITY 2'h0
`define DMSC_RST_STOP_METHOD 2'h3
`define DMSC_RST_DETECT_EN 1'h1
`define DMSC_RST_DETECT_TIME 8'h14

// Highest legal codes
`define DMSC_MAX_BAUD 4'h8
`define DMSC_MAX_PARITY 2'h2
`define DMSC_MAX_DETECT_TIME 8'hFA

// Reload-now value
`define DMSC_RELOAD_NOW 16'h0001

// Interrupt status bit positions
`define DMSC_IRQ_CE 0
`define DMSC_IRQ_HIT 1
`define DMSC_IRQ_DROP 2
`define DMSC_IRQ_RELOAD 3
`define DMSC_IRQ_W 4

// Active settings readback field positions
`define DMSC_ACT_ADDR_LSB 0
`define DMSC_ACT_BAUD_LSB 8
`define DMSC_ACT_PAR_LSB 12
`define DMSC_ACT_CE_BIT 14

// Timing: core clock and the error timer unit
`define DMSC_CLK_HZ 100000000
`define DMSC_CE_UNIT_MS 100

`endif

// ### include/dmsc_pkg.sv
// Types of the Modbus serial configuration block
`default_nettype none
package dmsc_pkg;

  // Stop method on communication error
  typedef enum logic [1:0] {
    DMSC_STOP_RAMP = 2'h0,
    DMSC_STOP_COAST = 2'h1,
    DMSC_STOP_FAST = 2'h2,
    DMSC_STOP_ALARM = 2'h3
  } dmsc_stop_t;

  // Character parity
  typedef enum logic [1:0] {
    DMSC_PAR_NONE = 2'h0,
    DMSC_PAR_EVEN = 2'h1,
    DMSC_PAR_ODD = 2'h2
  } dmsc_parity_t;

  // Link supervision state
  typedef enum logic [1:0] {
    DMSC_MON_IDLE = 2'h0,
    DMSC_MON_WATCH = 2'h1,
    DMSC_MON_ERROR = 2'h2
  } dmsc_mon_t;

endpackage
`default_nettype wire

// ### logic/dmsc_baud_gen.sv
// Bit-rate enable pulse generator for the serial link
`default_nettype none
module dmsc_baud_gen
  import dmsc_pkg::*;
#(
  parameter int CLK_HZ = 100000000
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] baud_code,
  output logic bit_tick
);

  // Clock cycles per bit for each speed code
  function automatic logic [16:0] bit_cycles(input logic [3:0] code);
    int rate;
    case (code)
      4'h0: rate = 1200;
      4'h1: rate = 2400;
      4'h2: rate = 4800;
      4'h3: rate = 9600;
      4'h4: rate = 19200;
      4'h5: rate = 38400;
      4'h6: rate = 57600;
      4'h7: rate = 76800;
      4'h8: rate = 115200;
      default: rate = 9600;
    endcase
    return 17'((CLK_HZ + rate / 2) / rate);
  endfunction

  logic [16:0] count;
  logic [3:0] last_code;

  // Divider; restarts when the active speed changes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 17'h00000;
      last_code <= 4'h0;
      bit_tick <= 1'b0;
    end else begin
      last_code <= baud_code;
      if (last_code != baud_code || count >= bit_cycles(baud_code) - 17'h00001) begin
        count <= 17'h00000;
        bit_tick <= (last_code == baud_code);
      end else begin
        count <= count + 17'h00001;
        bit_tick <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### logic/dmsc_core.sv
// Modbus serial port configuration, address filter and communication error response
`include "dmsc_defs.svh"
`default_nettype none
module dmsc_core
  import dmsc_pkg::*;
#(
  parameter int CE_UNIT_CYCLES = (`DMSC_CLK_HZ / 1000) * `DMSC_CE_UNIT_MS
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_valid,
  input wire logic rx_frame_start,
  input wire logic [7:0] rx_data,
  input wire logic tx_request,
  input wire logic fault_reset,
  output logic rs485_de,
  output logic frame_hit,
  output logic frame_drop,
  output logic frame_owned,
  output logic bit_tick,
  output logic [3:0] active_baud,
  output logic [1:0] active_parity,
  output logic ramp_stop,
  output logic coast_stop,
  output logic fast_stop,
  output logic fault_out,
  output logic alarm_out,
  output logic ce_display,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta;
  logic rst_n;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [7:0] node_address;
  logic [3:0] baud_rate_code;
  logic [1:0] parity_code;
  dmsc_stop_t comm_error_stop_method;
  logic comm_error_detect_enable;
  logic [7:0] comm_error_detect_time;
  logic [7:0] active_addr;
  logic [`DMSC_IRQ_W-1:0] irq_status;
  logic [`DMSC_IRQ_W-1:0] irq_enable;
  logic [`DMSC_IRQ_W-1:0] irq_events;
  logic comm_error;
  logic acc;
  logic wr;
  logic reload;
  logic [13:0] idx;
  logic [31:0] next_readdata;

  // Register index of a word access
  function automatic logic hit(input logic [13:0] index, input logic [13:0] target);
    return index == target;
  endfunction

  assign idx = avs_address[15:2];
  assign acc = (avs_read || avs_write) && avs_waitrequest;
  // Write lands at the answer edge, where the master sees waitrequest low
  assign wr = avs_write && !avs_waitrequest && avs_address[1:0] == 2'h0;
  assign reload = wr && hit(idx, `DMSC_IDX_RELOAD) && avs_writedata[15:0] == `DMSC_RELOAD_NOW;

  // One wait cycle, then answer for one cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !acc;
    end
  end

  // Read data decode; unmapped reads give zero
  always_comb begin
    next_readdata = 32'h00000000;
    if (avs_address[1:0] == 2'h0) begin
      case (idx)
        `DMSC_IDX_NODE_ADDR: next_readdata[7:0] = node_address;
        `DMSC_IDX_BAUD: next_readdata[3:0] = baud_rate_code;
        `DMSC_IDX_PARITY: next_readdata[1:0] = parity_code;
        `DMSC_IDX_STOP_METHOD: next_readdata[1:0] = comm_error_stop_method;
        `DMSC_IDX_DETECT_EN: next_readdata[0] = comm_error_detect_enable;
        `DMSC_IDX_DETECT_TIME: next_readdata[7:0] = comm_error_detect_time;
        `DMSC_IDX_IRQ_STATUS: next_readdata[`DMSC_IRQ_W-1:0] = irq_status;
        `DMSC_IDX_IRQ_ENABLE: next_readdata[`DMSC_IRQ_W-1:0] = irq_enable;
        `DMSC_IDX_ACTIVE: begin
          next_readdata[`DMSC_ACT_ADDR_LSB+:8] = active_addr;
          next_readdata[`DMSC_ACT_BAUD_LSB+:4] = active_baud;
          next_readdata[`DMSC_ACT_PAR_LSB+:2] = active_parity;
          next_readdata[`DMSC_ACT_CE_BIT] = comm_error;
        end
        default: next_readdata = 32'h00000000;
      endcase
    end
  end

  // Read data captured with the answer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (acc && avs_read) begin
      avs_readdata <= next_readdata;
    end
  end

  // Settings; out-of-range codes leave the old value
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      node_address <= `DMSC_RST_NODE_ADDR;
      baud_rate_code <= `DMSC_RST_BAUD;
      parity_code <= `DMSC_RST_PARITY;
      comm_error_stop_method <= dmsc_stop_t'(`DMSC_RST_STOP_METHOD);
      comm_error_detect_enable <= `DMSC_RST_DETECT_EN;
      comm_error_detect_time <= `DMSC_RST_DETECT_TIME;
    end else if (wr) begin
      if (hit(idx, `DMSC_IDX_NODE_ADDR) && avs_writedata[15:8] == 8'h00) begin
        node_address <= avs_writedata[7:0];
      end
      if (hit(idx, `DMSC_IDX_BAUD) && avs_writedata[15:0] <= 16'(`DMSC_MAX_BAUD)) begin
        baud_rate_code <= avs_writedata[3:0];
      end
      if (hit(idx, `DMSC_IDX_PARITY) && avs_writedata[15:0] <= 16'(`DMSC_MAX_PARITY)) begin
        parity_code <= avs_writedata[1:0];
      end
      if (hit(idx, `DMSC_IDX_STOP_METHOD) && avs_writedata[15:2] == 14'h0000) begin
        comm_error_stop_method <= dmsc_stop_t'(avs_writedata[1:0]);
      end
      if (hit(idx, `DMSC_IDX_DETECT_EN) && avs_writedata[15:1] == 15'h0000) begin
        comm_error_detect_enable <= avs_writedata[0];
      end
      if (hit(idx, `DMSC_IDX_DETECT_TIME) && avs_writedata[15:0] <= 16'(`DMSC_MAX_DETECT_TIME)) begin
        comm_error_detect_time <= avs_writedata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Active link settings
  // Shadow copy only on reset or reload-now
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_addr <= `DMSC_RST_NODE_ADDR;
      active_baud <= `DMSC_RST_BAUD;
      active_parity <= `DMSC_RST_PARITY;
    end else if (reload) begin
      active_addr <= node_address;
      active_baud <= baud_rate_code;
      active_parity <= parity_code;
    end
  end

  // Bit-rate enable for the character framer
  dmsc_baud_gen #(
    .CLK_HZ(`DMSC_CLK_HZ)
  ) u_baud (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .baud_code(active_baud),
    .bit_tick(bit_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address filter and line driver
  // Address byte of each frame decides ownership
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_owned <= 1'b0;
      frame_hit <= 1'b0;
      frame_drop <= 1'b0;
    end else begin
      frame_hit <= 1'b0;
      frame_drop <= 1'b0;
      if (reload) begin
        frame_owned <= 1'b0;
      end else if (rx_valid && rx_frame_start) begin
        frame_owned <= active_addr != 8'h00 && rx_data == active_addr;
        frame_hit <= active_addr != 8'h00 && rx_data == active_addr;
        frame_drop <= active_addr == 8'h00 || rx_data != active_addr;
      end
    end
  end

  // Transmit only for an owned frame at a nonzero address
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs485_de <= 1'b0;
    end else begin
      rs485_de <= tx_request && frame_owned && active_addr != 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Communication error supervision
  dmsc_mon_t mon_state;
  logic [31:0] unit_count;
  logic [7:0] idle_units;
  logic ce_event;

  // Link silence timer in detection units
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_count <= 32'h00000000;
      idle_units <= 8'h00;
    end else if (rx_valid || mon_state != DMSC_MON_WATCH) begin
      unit_count <= 32'h00000000;
      idle_units <= 8'h00;
    end else if (unit_count >= 32'(CE_UNIT_CYCLES - 1)) begin
      unit_count <= 32'h00000000;
      idle_units <= idle_units + 8'h01;
    end else begin
      unit_count <= unit_count + 32'h00000001;
    end
  end

  assign ce_event = mon_state == DMSC_MON_WATCH && !rx_valid && idle_units >= comm_error_detect_time
    && comm_error_detect_time != 8'h00;

  // Watch starts at the first received data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_state <= DMSC_MON_IDLE;
    end else begin
      case (mon_state)
        DMSC_MON_IDLE: begin
          if (rx_valid && comm_error_detect_enable) begin
            mon_state <= DMSC_MON_WATCH;
          end
        end
        DMSC_MON_WATCH: begin
          if (!comm_error_detect_enable) begin
            mon_state <= DMSC_MON_IDLE;
          end else if (ce_event) begin
            mon_state <= DMSC_MON_ERROR;
          end
        end
        DMSC_MON_ERROR: begin
          if (fault_reset) begin
            mon_state <= DMSC_MON_IDLE;
          end
        end
        default: mon_state <= DMSC_MON_IDLE;
      endcase
    end
  end

  assign comm_error = mon_state == DMSC_MON_ERROR;

  // Stop reaction chosen by the stop method
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_stop <= 1'b0;
      coast_stop <= 1'b0;
      fast_stop <= 1'b0;
      fault_out <= 1'b0;
      alarm_out <= 1'b0;
      ce_display <= 1'b0;
    end else begin
      ramp_stop <= comm_error && comm_error_stop_method == DMSC_STOP_RAMP;
      coast_stop <= comm_error && comm_error_stop_method == DMSC_STOP_COAST;
      fast_stop <= comm_error && comm_error_stop_method == DMSC_STOP_FAST;
      fault_out <= comm_error && comm_error_stop_method != DMSC_STOP_ALARM;
      alarm_out <= comm_error && comm_error_stop_method == DMSC_STOP_ALARM;
      ce_display <= comm_error;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts
  always_comb begin
    irq_events = '0;
    irq_events[`DMSC_IRQ_CE] = ce_event;
    irq_events[`DMSC_IRQ_HIT] = frame_hit;
    irq_events[`DMSC_IRQ_DROP] = frame_drop;
    irq_events[`DMSC_IRQ_RELOAD] = reload;
  end

  // Sticky status; a new event wins over a clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else if (wr && hit(idx, `DMSC_IDX_IRQ_CLEAR)) begin
      irq_status <= (irq_status & ~avs_writedata[`DMSC_IRQ_W-1:0]) | irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end

  // Enable mask
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable <= '0;
    end else if (wr && hit(idx, `DMSC_IDX_IRQ_ENABLE)) begin
      irq_enable <= avs_writedata[`DMSC_IRQ_W-1:0];
    end
  end

  // Level interrupt
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

endmodule
`default_nettype wire

// ### test/dmsc_core_props.sv
// Port checker for the Modbus serial configuration core
`default_nettype none
module dmsc_core_props
  import dmsc_pkg::*;
#(
  parameter int CE_UNIT_CYCLES = 10
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic rx_valid,
  input wire logic rx_frame_start,
  input wire logic tx_request,
  input wire logic rs485_de,
  input wire logic frame_hit,
  input wire logic frame_drop,
  input wire logic frame_owned,
  input wire logic [3:0] active_baud,
  input wire logic [1:0] active_parity,
  input wire logic ramp_stop,
  input wire logic coast_stop,
  input wire logic fast_stop,
  input wire logic fault_out,
  input wire logic alarm_out,
  input wire logic ce_display
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  // Address byte and its verdict one cycle on
  sequence s_addr_byte;
    rx_valid && rx_frame_start;
  endsequence
  sequence s_verdict;
    ##1 (frame_hit ^ frame_drop);
  endsequence
  a_addr_verdict: assert property (s_addr_byte |-> s_verdict)
    else $error("address byte not judged");
  a_judge_cause: assert property ((frame_hit || frame_drop) |-> $past(rx_valid && rx_frame_start))
    else $error("verdict without address byte");
  a_hit_owned: assert property (frame_hit |-> frame_owned)
    else $error("hit without ownership");
  a_de_cause: assert property (rs485_de |-> $past(tx_request) && $past(frame_owned))
    else $error("driver enabled without owned request");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  a_active_reload: assert property ($changed({active_baud, active_parity}) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("active settings moved without write");
  a_stop_fault: assert property (fault_out == (ramp_stop || coast_stop || fast_stop))
    else $error("fault output not tied to stop");
  a_one_stop: assert property ($onehot0({ramp_stop, coast_stop, fast_stop, alarm_out}))
    else $error("several reactions at once");
  a_error_shown: assert property ((fault_out || alarm_out) |-> ce_display)
    else $error("error reaction without display");
endmodule
bind dmsc_core dmsc_core_props #(.CE_UNIT_CYCLES(CE_UNIT_CYCLES)) dmsc_core_props_i (
  .core_clk(core_clk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_frame_start(rx_frame_start),
  .tx_request(tx_request), .rs485_de(rs485_de), .frame_hit(frame_hit), .frame_drop(frame_drop),
  .frame_owned(frame_owned), .active_baud(active_baud), .active_parity(active_parity),
  .ramp_stop(ramp_stop), .coast_stop(coast_stop), .fast_stop(fast_stop), .fault_out(fault_out),
  .alarm_out(alarm_out), .ce_display(ce_display));
`default_nettype wire

// ### test/dmsc_master_model.sv
// Bus master and framer stand-in on the serial side
`default_nettype none
module dmsc_master_model (
  input wire logic core_clk,
  output logic rx_valid,
  output logic rx_frame_start,
  output logic [7:0] rx_data,
  output logic tx_request
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle line at time zero
  initial begin
    rx_valid = 1'b0;
    rx_frame_start = 1'b0;
    rx_data = 8'hA5;
    tx_request = 1'b0;
  end
  // One byte; released data shows the inverse
  task automatic send(input logic [7:0] b, input logic s);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_frame_start <= s;
    rx_data <= b;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_frame_start <= 1'b0;
    rx_data <= ~b;
  endtask
  // Response window of n cycles
  task automatic reply(input int n);
    @(posedge core_clk);
    tx_request <= 1'b1;
    repeat (n) @(posedge core_clk);
    tx_request <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/drive_modbus_serial_config_tb_top.sv
// Self-checking bench of the Modbus serial configuration core
`include "dmsc_defs.svh"
`default_nettype none
module drive_modbus_serial_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic fault_reset = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, rx_valid, rx_frame_start, tx_request, rs485_de, frame_hit, frame_drop, frame_owned;
  logic bit_tick, ramp_stop, coast_stop, fast_stop, fault_out, alarm_out, ce_display, irq;
  logic [7:0] rx_data, a;
  logic [3:0] active_baud, b;
  logic [1:0] active_parity, p;
  int fail_count = 0;
  int check_count = 0;
  int n;
  logic [13:0] idx_t[6] = '{`DMSC_IDX_NODE_ADDR, `DMSC_IDX_BAUD, `DMSC_IDX_PARITY, `DMSC_IDX_STOP_METHOD,
    14'h0600, `DMSC_IDX_ACTIVE};
  logic [31:0] rst_t[6] = '{32'h1F, 32'h3, 32'h0, 32'h3, 32'h0, 32'h31F};
  ////////////////////////////////////////////////////////////
  always #5 core_clk = ~core_clk;
  dmsc_core #(.CE_UNIT_CYCLES(10)) dmsc_core_i (
    .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_frame_start(rx_frame_start),
    .rx_data(rx_data), .tx_request(tx_request), .fault_reset(fault_reset), .rs485_de(rs485_de),
    .frame_hit(frame_hit), .frame_drop(frame_drop), .frame_owned(frame_owned), .bit_tick(bit_tick),
    .active_baud(active_baud), .active_parity(active_parity), .ramp_stop(ramp_stop),
    .coast_stop(coast_stop), .fast_stop(fast_stop), .fault_out(fault_out), .alarm_out(alarm_out),
    .ce_display(ce_display), .irq(irq));
  dmsc_master_model dmsc_master_model_i (.core_clk(core_clk), .rx_valid(rx_valid),
    .rx_frame_start(rx_frame_start), .rx_data(rx_data), .tx_request(tx_request));
  ////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [13:0] idx, input logic [15:0] d);
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Cycles between bit pulses for a speed code
  function automatic int period(input logic [3:0] c);
    int r[9] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 76800, 115200};
    return (`DMSC_CLK_HZ + r[c] / 2) / r[c];
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'hB5096D64));
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (idx_t[i]) begin
      bus(0, idx_t[i], 0);
      check(q, rst_t[i]);
    end
    bus(1, `DMSC_IDX_DETECT_EN, 16'h0002);
    bus(0, `DMSC_IDX_DETECT_EN, 0);
    check(q, 1);
    bus(1, `DMSC_IDX_BAUD, 16'h0009);
    bus(0, `DMSC_IDX_BAUD, 0);
    check(q, 3);
    a = 8'h40 + 8'($urandom % 64);
    b = 4'h4 + 4'($urandom % 5);
    p = 2'($urandom % 3);
    bus(1, `DMSC_IDX_NODE_ADDR, {8'h00, a});
    bus(1, `DMSC_IDX_BAUD, {12'h000, b});
    bus(1, `DMSC_IDX_PARITY, {14'h0000, p});
    check({active_parity, active_baud}, 6'h03);
    bus(1, `DMSC_IDX_RELOAD, 16'h0001);
    repeat (2) @(posedge core_clk);
    #1;
    check({active_parity, active_baud}, {p, b});
    bus(0, `DMSC_IDX_ACTIVE, 0);
    check(q[7:0], a);
    repeat (2) begin
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (bit_tick !== 1'b1 && n < 9000);
    end
    check(n, period(b));
    dmsc_master_model_i.send(a, 1'b1);
    #1;
    check({frame_hit, frame_drop, frame_owned}, 3'b101);
    dmsc_master_model_i.reply(3);
    #1;
    check(rs485_de, 1);
    dmsc_master_model_i.send(~a, 1'b1);
    #1;
    check({frame_hit, frame_drop, frame_owned}, 3'b010);
    dmsc_master_model_i.reply(3);
    #1;
    check(rs485_de, 0);
    bus(1, `DMSC_IDX_NODE_ADDR, 16'h0000);
    bus(1, `DMSC_IDX_RELOAD, 16'h0001);
    dmsc_master_model_i.send(8'h00, 1'b1);
    #1;
    check({frame_hit, frame_drop}, 2'b01);
    dmsc_master_model_i.reply(3);
    #1;
    check(rs485_de, 0);
    // Each stop method after silence, then clear and mask
    for (int m = 0; m < 5; m++) begin
      bus(1, `DMSC_IDX_DETECT_TIME, 16'h0000);
      fault_reset <= 1'b1;
      @(posedge core_clk);
      fault_reset <= 1'b0;
      bus(1, `DMSC_IDX_IRQ_CLEAR, 16'h000F);
      repeat (2) @(posedge core_clk);
      #1;
      check({irq, ce_display, fault_out, alarm_out}, 4'h0);
      if (m == 4) break;
      bus(1, `DMSC_IDX_STOP_METHOD, 16'(m));
      bus(1, `DMSC_IDX_IRQ_ENABLE, 16'(m != 0));
      dmsc_master_model_i.send(8'h55, 1'b0);
      bus(1, `DMSC_IDX_DETECT_TIME, 16'h0002);
      repeat (5) @(posedge core_clk);
      #1;
      check(ce_display, 0);
      repeat (30) @(posedge core_clk);
      #1;
      check({ramp_stop, coast_stop, fast_stop, fault_out, alarm_out, ce_display, irq},
        {m == 0, m == 1, m == 2, m < 3, m == 3, 1'b1, m != 0});
      bus(0, `DMSC_IDX_IRQ_STATUS, 0);
      check(q[0], 1);
    end
    final_report();
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
